// ---- rtl/dfs_pkg.sv ----
// package of constants and types for the duplex feed sequencer
package dfs_pkg;
	// =====================================================
	// clock and time base
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned TICK_US = 1_000; // 1 ms tick
	localparam int unsigned TICK_DIV_DEF = CLK_HZ / 1_000_000 * TICK_US;
	// =====================================================
	// jam timeouts and sequence step times in milliseconds
	localparam int unsigned REVERSE_TO_MS = 1_100;
	localparam int unsigned DUPLEX_TO_MS = 1_500;
	localparam int unsigned PICKUP_TO_MS = 3_300;
	localparam int unsigned REVERSE_DELAY_MS_DEF = 50;
	localparam int unsigned REG_TIME_MS_DEF = 200;
	localparam int TMR_W = 12;
	// =====================================================
	// link commands
	localparam int CMD_W = 4;
	localparam logic [3:0] CMD_NONE = 4'h0;
	localparam logic [3:0] CMD_TIMING = 4'h1;
	localparam logic [3:0] CMD_PICKUP = 4'h2;
	localparam logic [3:0] CMD_AUTO_DELIVER = 4'h3;
	localparam logic [3:0] CMD_ABORT = 4'h4;
	localparam logic [3:0] CMD_CLEAR_JAM = 4'h5;
	// =====================================================
	// jam codes and status layout
	localparam int JAM_W = 2;
	localparam logic [1:0] JAM_NONE = 2'h0;
	localparam logic [1:0] JAM_REVERSE = 2'h1;
	localparam logic [1:0] JAM_DUPLEX = 2'h2;
	localparam logic [1:0] JAM_PICKUP = 2'h3;
	localparam int STAT_W = 8;
	// =====================================================
	// sequencer states, gray along the path
	typedef enum logic [2:0] {
		DFS_IDLE = 3'b000,
		DFS_WAIT_REV = 3'b001,
		DFS_REVERSE = 3'b011,
		DFS_DRAW_IN = 3'b010,
		DFS_REGISTER = 3'b110,
		DFS_REFEED = 3'b111,
		DFS_JAM = 3'b101,
		DFS_DELIVER = 3'b100
	} dfs_state_t;
endpackage

// ---- rtl/dfs_timer.sv ----
// tick-based jam timeout counter
`timescale 1ns/1ps
module dfs_timer
	import dfs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// control
	input wire logic tick_in,
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic [TMR_W-1:0] limit_in,
	// result
	output logic expired_out
);
	logic [TMR_W-1:0] count_r;
	logic run_r;

	// start at trigger edge, clear when expected sensor asserts
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			count_r <= '0;
			run_r <= 1'b0;
			expired_out <= 1'b0;
		end
		else if (stop_in)
		begin
			run_r <= 1'b0;
			count_r <= '0;
			expired_out <= 1'b0;
		end
		else if (start_in)
		begin
			run_r <= 1'b1;
			count_r <= '0;
			expired_out <= 1'b0;
		end
		else if (run_r && tick_in)
		begin
			if (count_r + TMR_W'(1) >= limit_in)
			begin
				run_r <= 1'b0;
				expired_out <= 1'b1;
			end
			count_r <= count_r + TMR_W'(1);
		end
		else
		begin
			expired_out <= 1'b0;
		end
	end
endmodule // dfs_timer

// ---- rtl/dfs_sequencer.sv ----
// duplex feed sequencer and jam supervisor
//
// Overview of operation
// - after timing and a fixed wait, reverse the delivery roller.
// - after draw-in, do horizontal registration, then refeed into engine.
// - no feed-sensor paper 1.1 s after fuser-exit trailing edge: jam.
// - no jam-sensor paper 1.5 s after feed-sensor leading edge: jam.
// - no top-of-page paper 3.3 s after duplex pickup starts: jam.
// - jams decided by sampling sensors at fixed stored check times.
// - on any jam halt the duplex feed and notify the formatter.
// - offer auto delivery when jam or feed sensor sees paper pre-print.
// - while fitted, the unit drives delivery rollers forward on fwd_delivery_req_in or in auto delivery, except in reverse and draw-in.
// - execute engine commands on motor and clutch, return status.
`timescale 1ns/1ps
module dfs_sequencer
	import dfs_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_DIV_DEF,
	parameter int unsigned REV_DELAY_MS = REVERSE_DELAY_MS_DEF,
	parameter int unsigned REG_MS = REG_TIME_MS_DEF
)
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// command link from engine controller
	input wire logic cmd_valid_in,
	input wire logic [CMD_W-1:0] cmd_in,
	input wire logic unit_fitted_in,
	input wire logic print_active_in,
	input wire logic fwd_delivery_req_in,
	// paper sensors (pins)
	input wire logic duplex_jam_sensor_in,
	input wire logic duplex_feed_sensor_in,
	input wire logic top_of_page_sensor_in,
	input wire logic fuser_exit_sensor_in,
	// loads
	output logic deliv_fwd_out,
	output logic deliv_rev_out,
	output logic feed_motor_out,
	output logic reg_clutch_out,
	// status toward engine controller
	output logic [STAT_W-1:0] status_out,
	output logic jam_notify_out
);
	// =====================================================
	// pin synchronisers
	logic [3:0] sens_s1_r, sens_s2_r, sens_d_r;
	logic jam_s, feed_s, top_s, fuse_s;
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sens_s1_r <= '0;
			sens_s2_r <= '0;
			sens_d_r <= '0;
		end
		else
		begin
			sens_s1_r <= {fuser_exit_sensor_in, top_of_page_sensor_in,
				duplex_feed_sensor_in, duplex_jam_sensor_in};
			sens_s2_r <= sens_s1_r;
			sens_d_r <= sens_s2_r;
		end
	end
	assign {fuse_s, top_s, feed_s, jam_s} = sens_s2_r;
	logic fuse_fall, feed_rise, jam_rise, top_rise;
	assign fuse_fall = sens_d_r[3] && !fuse_s;
	assign top_rise = !sens_d_r[2] && top_s;
	assign feed_rise = !sens_d_r[1] && feed_s;
	assign jam_rise = !sens_d_r[0] && jam_s;

	// =====================================================
	// fixed-rate tick, the stored check-time base
	localparam int DIV_W = $clog2(TICK_DIV + 1);
	logic [DIV_W-1:0] div_r;
	logic tick;
	assign tick = (div_r == DIV_W'(TICK_DIV - 1));
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			div_r <= '0;
		else if (tick)
			div_r <= '0;
		else
			div_r <= div_r + DIV_W'(1);
	end

	// =====================================================
	// state and command decode
	dfs_state_t state_r;
	logic cmd_timing, cmd_pickup, cmd_deliver, cmd_abort, cmd_clear;
	assign cmd_timing = cmd_valid_in && cmd_in == CMD_TIMING;
	assign cmd_pickup = cmd_valid_in && cmd_in == CMD_PICKUP;
	assign cmd_deliver = cmd_valid_in && cmd_in == CMD_AUTO_DELIVER;
	assign cmd_abort = cmd_valid_in && cmd_in == CMD_ABORT;
	assign cmd_clear = cmd_valid_in && cmd_in == CMD_CLEAR_JAM;

	// =====================================================
	// jam timers
	logic rev_exp, dup_exp, pick_exp;
	logic in_flow;
	assign in_flow = state_r != DFS_IDLE && state_r != DFS_JAM;
	dfs_timer u_rev_timer (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.tick_in(tick),
		// armed at each trailing edge with feed_s low outside jam and deliver: the timing command only follows it,
		// so gating on the active sequence would never start this timer
		.start_in(fuse_fall),
		.stop_in(feed_s || state_r == DFS_JAM || state_r == DFS_DELIVER),
		.limit_in(TMR_W'(REVERSE_TO_MS)),
		.expired_out(rev_exp)
	);
	dfs_timer u_dup_timer (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.tick_in(tick),
		.start_in(in_flow && feed_rise),
		.stop_in(jam_s || !in_flow),
		.limit_in(TMR_W'(DUPLEX_TO_MS)),
		.expired_out(dup_exp)
	);
	logic pick_start;
	assign pick_start = state_r == DFS_REGISTER && cmd_pickup;
	dfs_timer u_pick_timer (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.tick_in(tick),
		.start_in(pick_start),
		.stop_in(top_rise || top_s || !in_flow),
		.limit_in(TMR_W'(PICKUP_TO_MS)),
		.expired_out(pick_exp)
	);

	// =====================================================
	// sequence step timer (reverse wait, registration dwell)
	logic [TMR_W-1:0] step_r;
	logic [JAM_W-1:0] jam_code_r;
	logic any_exp;
	assign any_exp = rev_exp || dup_exp || pick_exp;

	// main sequence: timing, wait, reverse, draw in, register, refeed
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_r <= DFS_IDLE;
			step_r <= '0;
		end
		else if (any_exp && in_flow)
		begin
			state_r <= DFS_JAM;
			step_r <= '0;
		end
		else
		begin
			if (tick)
				step_r <= step_r + TMR_W'(1);
			unique case (state_r)
				DFS_IDLE:
				begin
					step_r <= '0;
					if (cmd_timing && unit_fitted_in)
						state_r <= DFS_WAIT_REV;
					else if (cmd_deliver && (jam_s || feed_s))
						state_r <= DFS_DELIVER;
				end
				DFS_WAIT_REV:
					if (step_r >= TMR_W'(REV_DELAY_MS))
						state_r <= DFS_REVERSE;
				DFS_REVERSE:
					if (feed_s)
						state_r <= DFS_DRAW_IN;
				DFS_DRAW_IN:
					if (jam_s)
					begin
						state_r <= DFS_REGISTER;
						step_r <= '0;
					end
				DFS_REGISTER:
					if (pick_start && step_r >= TMR_W'(REG_MS))
						state_r <= DFS_REFEED;
				DFS_REFEED:
					if (top_s)
						state_r <= DFS_IDLE;
				DFS_JAM:
					if (cmd_clear)
						state_r <= DFS_IDLE;
				DFS_DELIVER:
					if (!jam_s && !feed_s)
						state_r <= DFS_IDLE;
			endcase
			if (cmd_abort && state_r != DFS_JAM)
				state_r <= DFS_IDLE;
		end
	end

	// latch jam type; first timeout wins
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			jam_code_r <= JAM_NONE;
		else if (in_flow && rev_exp)
			jam_code_r <= JAM_REVERSE;
		else if (in_flow && dup_exp)
			jam_code_r <= JAM_DUPLEX;
		else if (in_flow && pick_exp)
			jam_code_r <= JAM_PICKUP;
		else if (state_r == DFS_JAM && cmd_clear)
			jam_code_r <= JAM_NONE;
	end

	// =====================================================
	// loads and status, all registered
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			deliv_fwd_out <= 1'b0;
			deliv_rev_out <= 1'b0;
			feed_motor_out <= 1'b0;
			reg_clutch_out <= 1'b0;
			jam_notify_out <= 1'b0;
			status_out <= '0;
		end
		else
		begin
			deliv_rev_out <= unit_fitted_in && (state_r == DFS_REVERSE ||
				state_r == DFS_DRAW_IN);
			deliv_fwd_out <= unit_fitted_in && (fwd_delivery_req_in ||
				state_r == DFS_DELIVER) && state_r != DFS_REVERSE &&
				state_r != DFS_DRAW_IN;
			feed_motor_out <= state_r == DFS_DRAW_IN ||
				state_r == DFS_REFEED || state_r == DFS_DELIVER;
			reg_clutch_out <= state_r == DFS_REGISTER;
			jam_notify_out <= state_r == DFS_JAM;
			status_out <= {state_r, jam_code_r,
				!print_active_in && (jam_s || feed_s),
				state_r == DFS_JAM, unit_fitted_in};
		end
	end
endmodule // dfs_sequencer

// ---- sim/dfs_sequencer_checker.sv ----
// port assertions for the duplex feed sequencer
`timescale 1ns/1ps
module dfs_sequencer_checker
	import dfs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// inputs watched
	input wire logic cmd_valid_in,
	input wire logic [CMD_W-1:0] cmd_in,
	input wire logic unit_fitted_in,
	// outputs watched
	input wire logic deliv_fwd_out,
	input wire logic deliv_rev_out,
	input wire logic feed_motor_out,
	input wire logic reg_clutch_out,
	input wire logic [STAT_W-1:0] status_out,
	input wire logic jam_notify_out
);
	// ==========================================
	// properties, one clock domain
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	a_jam_halts_loads: assert property (
		jam_notify_out |-> !deliv_rev_out && !feed_motor_out && !reg_clutch_out)
		else $error("loads run while jammed");
	a_jam_has_code: assert property (
		$rose(jam_notify_out) |-> status_out[1] && status_out[4:3] != JAM_NONE)
		else $error("jam without code");
	a_reverse_in_state: assert property (
		deliv_rev_out |-> status_out[7:5] == 3'h3 || status_out[7:5] == 3'h2)
		else $error("reverse outside reverse or draw-in state");
	a_reverse_runs: assert property (
		status_out[7:5] == 3'h3 && status_out[0] |-> deliv_rev_out)
		else $error("roller not reversing in reverse state");
	a_clutch_in_reg: assert property (
		reg_clutch_out |-> status_out[7:5] == 3'h6)
		else $error("clutch outside registration");
	a_timing_starts_wait: assert property (
		cmd_valid_in && cmd_in == CMD_TIMING && unit_fitted_in
		&& status_out[7:5] == 3'h0 && $past(status_out[7:5]) == 3'h0
		|-> ##[1:2] status_out[7:5] == 3'h1)
		else $error("timing command not taken");
	a_unfitted_quiet: assert property (
		!unit_fitted_in [*3] |-> !deliv_fwd_out && !deliv_rev_out)
		else $error("rollers driven while absent");
	a_fitted_flag: assert property (
		$rose(unit_fitted_in) |-> ##[1:2] status_out[0])
		else $error("fitted flag late");
	a_jam_clear_only: assert property (
		$fell(jam_notify_out)
		|-> $past(cmd_valid_in && cmd_in == CMD_CLEAR_JAM, 2))
		else $error("jam left without clear");
endmodule // dfs_sequencer_checker

bind dfs_sequencer dfs_sequencer_checker chk_i (
	.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
	.cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
	.unit_fitted_in(unit_fitted_in), .deliv_fwd_out(deliv_fwd_out),
	.deliv_rev_out(deliv_rev_out), .feed_motor_out(feed_motor_out),
	.reg_clutch_out(reg_clutch_out), .status_out(status_out),
	.jam_notify_out(jam_notify_out));

// ---- sim/dfs_engine_model.sv ----
// engine controller model driving the command link
`timescale 1ns/1ps
module dfs_engine_model
	import dfs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// sheet leaving the fuser
	input wire logic fuser_exit_sensor_in,
	// command link
	output logic cmd_valid_out,
	output logic [CMD_W-1:0] cmd_out
);
	logic fx_r;
	// ==========================================
	// one-cycle command; idle link shows the inverse code
	task automatic send(input logic [CMD_W-1:0] c);
		@(posedge ref_clk_in);
		cmd_valid_out <= 1'b1;
		cmd_out <= c;
		@(posedge ref_clk_in);
		cmd_valid_out <= 1'b0;
		cmd_out <= ~c;
	endtask
	initial
	begin
		cmd_valid_out = 1'b0;
		cmd_out = 4'h0;
		fx_r = 1'b0;
	end
	// timing goes out only after the trailing edge at fuser exit
	always @(posedge ref_clk_in)
	begin
		if (reset_n_in && fx_r && !fuser_exit_sensor_in)
			send(CMD_TIMING);
		fx_r = fuser_exit_sensor_in;
	end
endmodule // dfs_engine_model

// ---- sim/tb_duplex_feed_sequencer.sv ----
// testbench for the duplex feed sequencer
`timescale 1ns/1ps
module tb_duplex_feed_sequencer
	import dfs_pkg::*;
();
	localparam int TD = 4;
	logic clk, rst_n, cv, fit, pa, fr, js, fs, ts, fx;
	logic fwd, rev, mot, clu, jn;
	logic [CMD_W-1:0] cmd;
	logic [STAT_W-1:0] st;
	int miscompares, checks, cyc;
	// ==========================================
	// design and engine model
	dfs_sequencer #(.TICK_DIV(TD), .REV_DELAY_MS(2), .REG_MS(3)) dut (
		.ref_clk_in(clk), .reset_n_in(rst_n), .cmd_valid_in(cv),
		.cmd_in(cmd), .unit_fitted_in(fit), .print_active_in(pa),
		.fwd_delivery_req_in(fr), .duplex_jam_sensor_in(js),
		.duplex_feed_sensor_in(fs), .top_of_page_sensor_in(ts),
		.fuser_exit_sensor_in(fx), .deliv_fwd_out(fwd),
		.deliv_rev_out(rev), .feed_motor_out(mot), .reg_clutch_out(clu),
		.status_out(st), .jam_notify_out(jn));
	dfs_engine_model eng (.ref_clk_in(clk), .reset_n_in(rst_n),
		.fuser_exit_sensor_in(fx), .cmd_valid_out(cv), .cmd_out(cmd));
	// ==========================================
	// shared helpers
	task chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task ws(input logic [2:0] s, output int n);
		n = 0;
		while (st[7:5] !== s && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		chk({5'h0, st[7:5]}, {5'h0, s});
	endtask
	task sheet(input int k);
		int n;
		fx <= 1;
		repeat (4) @(posedge clk);
		fx <= 0;
		if (k == 0) return;
		ws(3'h3, n);
		chk(rev, 1);
		fs <= 1;
		ws(3'h2, n);
		if (k == 1) return;
		js <= 1;
		ws(3'h6, n);
		chk(clu, 1);
		// engine measures the right-edge offset during the dwell
		repeat (3 * TD + 8) @(posedge clk);
		eng.send(CMD_PICKUP);
		ws(3'h7, n);
		chk(mot, 1);
		if (k == 2) return;
		ts <= 1;
		ws(3'h0, n);
		{fs, js, ts} <= 3'h0;
	endtask
	task wj(input int lo, input int hi, input logic [1:0] c);
		int n;
		ws(3'h5, n);
		chk({7'h0, n >= lo && n <= hi}, 8'h01);
		chk({6'h0, st[4:3]}, {6'h0, c});
		chk({jn, rev, mot, clu}, 8'h08);
		{fs, js, ts} <= 3'h0;
		eng.send(CMD_CLEAR_JAM);
		ws(3'h0, n);
	endtask
	// ==========================================
	// scenarios
	task t_refuse;
		eng.send(CMD_TIMING);
		repeat (6) @(posedge clk);
		chk({st[7:5], st[0], fwd}, 8'h00);
		fit <= 1;
		repeat (4) @(posedge clk);
		chk({st[0], fwd}, 8'h03);
		fr <= 0;
		repeat (3) @(posedge clk);
		chk({st[0], fwd}, 8'h02);
		fr <= 1;
		repeat (3) @(posedge clk);
	endtask
	task t_full;
		sheet(3);
		chk({rev, mot, clu, jn}, 8'h00);
	endtask
	task t_deliver;
		int n;
		pa <= 1;
		fs <= 1;
		repeat (6) @(posedge clk);
		chk(st[2], 0);
		pa <= 0;
		repeat (4) @(posedge clk);
		chk(st[2], 1);
		eng.send(CMD_AUTO_DELIVER);
		ws(3'h4, n);
		eng.send(CMD_ABORT);
		ws(3'h0, n);
		fs <= 0;
	endtask
	task t_jams;
		sheet(0);
		wj(1100 * TD - 8, 1100 * TD + 16, JAM_REVERSE);
		sheet(1);
		wj(1500 * TD - 12, 1500 * TD + 12, JAM_DUPLEX);
		sheet(2);
		wj(3300 * TD - 12, 3300 * TD + 12, JAM_PICKUP);
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========================================
	// clock, hang guard, main sequence
	initial
	begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			miscompares++;
			test_done;
		end
	end
	initial
	begin
		rst_n = 0;
		fit = 0;
		pa = 0;
		fr = 1;
		{js, fs, ts, fx} = 4'h0;
		miscompares = 0;
		checks = 0;
		cyc = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1;
		t_refuse;
		$display("t_refuse ended");
		t_full;
		$display("t_full ended");
		t_deliver;
		$display("t_deliver ended");
		t_jams;
		$display("t_jams ended");
		test_done;
	end
endmodule // tb_duplex_feed_sequencer
